/* File: inc/ptf_pkg.sv */
package ptf_pkg;
   // ==========================================================
   // Data-memory map
   localparam logic [6:0] SLOW_TICK_JUDGE_ADDR = 7'h6E;
   localparam logic [6:0] FAST_TICK_JUDGE_ADDR = 7'h6F;
   localparam int         FLAG_BIT             = 0;
   localparam logic [3:0] JUDGE_RESET          = 4'h0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 8;
   localparam int FAST_PERIOD_NS = 5_000_000;
   localparam int SLOW_PERIOD_NS = 125_000_000;
   localparam int FAST_CYCLES    = FAST_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SLOW_PER_FAST  = SLOW_PERIOD_NS / FAST_PERIOD_NS;
   localparam int FAST_CNT_W     = 20;
   localparam int SLOW_CNT_W     = 5;
endpackage

/* File: hdl/ptf_divider.sv */
`timescale 1ns/10ps
module ptf_divider #(
   parameter int FAST_CYCLES = ptf_pkg::FAST_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Timebase gate
   input  wire logic run,
   // One-cycle set pulses
   output logic      fast_tick,
   output logic      slow_tick
);
   logic [ptf_pkg::FAST_CNT_W-1:0] fast_cnt_reg;
   logic [ptf_pkg::SLOW_CNT_W-1:0] slow_cnt_reg;
   logic                           fast_wrap;
   logic                           slow_wrap;

   // ==========================================================
   // Shared counter chain: the slow stage counts fast wraps
   assign fast_wrap = run && (fast_cnt_reg == ptf_pkg::FAST_CNT_W'(FAST_CYCLES - 1));
   assign slow_wrap = fast_wrap && (slow_cnt_reg == ptf_pkg::SLOW_CNT_W'(ptf_pkg::SLOW_PER_FAST - 1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fast_cnt_reg <= '0;
         slow_cnt_reg <= '0;
         fast_tick    <= 1'b0;
         slow_tick    <= 1'b0;
      end else begin
         if (run) begin
            fast_cnt_reg <= fast_wrap ? '0 : fast_cnt_reg + 1'b1;
         end
         if (fast_wrap) begin
            slow_cnt_reg <= slow_wrap ? '0 : slow_cnt_reg + 1'b1;
         end
         fast_tick <= fast_wrap;
         slow_tick <= slow_wrap;
      end
   end
endmodule // ptf_divider

/* File: hdl/ptf_tick_flags.sv */
`timescale 1ns/10ps
// Behaviour
// - Slow tick flag is set every 125 ms (8 Hz).
// - Fast tick flag is set every 5 ms (200 Hz).
// - Flags appear at bit 0 of 6EH and 6FH, mirroring the carry flip-flops.
// - Flags are read-only; a qualifying read clears the flag read.
// - Qualifying read-and-clear instructions addressing 6EH or 6FH clear the flag.
// - Power-on reset clears both flags, first read returns 0.
// - After power-on a flag is not set by its tick until it has been read once; a chip-enable reset sets the slow flag regardless.
// - After CE rises, chip-enable reset fires at the next slow set pulse.
// - That chip-enable reset coincides with the pulse and leaves the slow flag at 1.
// - A slow flag read colliding with the pending reset pulse wins.
// - The reset is then postponed one full slow period.
// - Timebase keeps running with CE low; only clock-stop halts it.
module ptf_tick_flags #(
   parameter int FAST_CYCLES = ptf_pkg::FAST_CYCLES
) (
   // Clock and power-on reset
   input  wire logic       CLK,
   input  wire logic       RESET,
   // Chip-enable pin and clock-stop instruction
   input  wire logic       CE,
   input  wire logic       CLK_STOP,
   // Data-memory read-and-clear access
   input  wire logic [6:0] DM_ADDR,
   input  wire logic       DM_RD,
   output logic      [3:0] DM_RDATA,
   // Flags and chip-enable reset
   output logic            SLOW_TICK_FLAG,
   output logic            FAST_TICK_FLAG,
   output logic            CE_RESET
);
   logic ce_meta_reg;
   logic ce_sync_reg;
   logic ce_prev_reg;
   logic ce_pending_reg;
   logic slow_armed_reg;
   logic fast_armed_reg;
   logic fast_tick;
   logic slow_tick;
   logic slow_read;
   logic fast_read;
   logic ce_fire;
   logic slow_set;
   logic fast_set;
   logic slow_flag_next;
   logic fast_flag_next;
   logic ce_pending_next;
   logic [3:0] rdata_next;

   // ==========================================================
   // Timebase
   ptf_divider #(.FAST_CYCLES(FAST_CYCLES)) u_div (
      .clk       (CLK),
      .reset     (RESET),
      .run       (!CLK_STOP),
      .fast_tick (fast_tick),
      .slow_tick (slow_tick)
   );

   // ==========================================================
   // Decode; DM_RD is raised by the core only for read-and-clear instructions
   assign slow_read = DM_RD && (DM_ADDR == ptf_pkg::SLOW_TICK_JUDGE_ADDR);
   assign fast_read = DM_RD && (DM_ADDR == ptf_pkg::FAST_TICK_JUDGE_ADDR);

   // A read on the very pulse defers the reset to the next period
   assign ce_fire         = slow_tick && ce_pending_reg && !slow_read;
   assign ce_pending_next = ce_sync_reg && (ce_pending_reg ? !ce_fire : !ce_prev_reg);

   // Set wins over the read's clear, so a pulse on the read cycle is kept
   assign slow_set       = (slow_tick && slow_armed_reg) || ce_fire;
   assign fast_set       = fast_tick && fast_armed_reg;
   assign slow_flag_next = slow_set || (SLOW_TICK_FLAG && !slow_read);
   assign fast_flag_next = fast_set || (FAST_TICK_FLAG && !fast_read);

   assign rdata_next = slow_read ? {3'h0, SLOW_TICK_FLAG} :
                       fast_read ? {3'h0, FAST_TICK_FLAG} : ptf_pkg::JUDGE_RESET;

   // ==========================================================
   // CE pin synchroniser
   // Reset high so a pin already high at power-on is not taken as a rising edge
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         ce_meta_reg <= 1'b1;
         ce_sync_reg <= 1'b1;
         ce_prev_reg <= 1'b1;
      end else begin
         ce_meta_reg <= CE;
         ce_sync_reg <= ce_meta_reg;
         ce_prev_reg <= ce_sync_reg;
      end
   end

   // ==========================================================
   // Flags, arming and chip-enable reset
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         SLOW_TICK_FLAG <= 1'b0;
         FAST_TICK_FLAG <= 1'b0;
         slow_armed_reg <= 1'b0;
         fast_armed_reg <= 1'b0;
         ce_pending_reg <= 1'b0;
         CE_RESET       <= 1'b0;
         DM_RDATA       <= ptf_pkg::JUDGE_RESET;
      end else begin
         SLOW_TICK_FLAG <= slow_flag_next;
         FAST_TICK_FLAG <= fast_flag_next;
         slow_armed_reg <= slow_armed_reg || slow_read || ce_fire;
         fast_armed_reg <= fast_armed_reg || fast_read;
         ce_pending_reg <= ce_pending_next;
         CE_RESET       <= ce_fire;
         DM_RDATA       <= rdata_next;
      end
   end

   // ==========================================================
   // Checks; helper gap counters are only for the assertions
   logic [23:0] slow_gap_reg;
   logic [19:0] fast_gap_reg;
   logic        slow_gap_ok_reg;
   logic        fast_gap_ok_reg;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         slow_gap_reg    <= '0;
         fast_gap_reg    <= '0;
         slow_gap_ok_reg <= 1'b0;
         fast_gap_ok_reg <= 1'b0;
      end else begin
         slow_gap_reg    <= slow_tick ? '0 : slow_gap_reg + 1'b1;
         fast_gap_reg    <= fast_tick ? '0 : fast_gap_reg + 1'b1;
         // A stop on any edge of a period stretches it, the tick edge included
         slow_gap_ok_reg <= (slow_tick || slow_gap_ok_reg) && !CLK_STOP;
         fast_gap_ok_reg <= (fast_tick || fast_gap_ok_reg) && !CLK_STOP;
      end
   end

   property p_slow_rate;
      @(posedge CLK) disable iff (RESET)
      slow_tick && slow_gap_ok_reg |-> slow_gap_reg == 24'(FAST_CYCLES * ptf_pkg::SLOW_PER_FAST - 1);
   endproperty
   a_slow_rate: assert property (p_slow_rate) else $error("slow pulse spacing wrong");

   property p_fast_rate;
      @(posedge CLK) disable iff (RESET)
      fast_tick && fast_gap_ok_reg |-> fast_gap_reg == 20'(FAST_CYCLES - 1);
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("fast pulse spacing wrong");

   property p_chain;
      @(posedge CLK) disable iff (RESET)
      slow_tick |-> fast_tick;
   endproperty
   a_chain: assert property (p_chain) else $error("slow pulse off the fast chain");

   property p_read_data;
      @(posedge CLK) disable iff (RESET)
      slow_read |=> DM_RDATA == {3'h0, $past(SLOW_TICK_FLAG)};
   endproperty
   a_read_data: assert property (p_read_data) else $error("slow judge read data wrong");

   property p_read_clear;
      @(posedge CLK) disable iff (RESET)
      fast_read && !fast_tick |=> !FAST_TICK_FLAG;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("fast flag not cleared by read");

   property p_arm;
      @(posedge CLK) disable iff (RESET)
      $rose(SLOW_TICK_FLAG) |-> $past(slow_armed_reg) || $past(ce_fire);
   endproperty
   a_arm: assert property (p_arm) else $error("slow flag set before first read");

   property p_ce_fire;
      @(posedge CLK) disable iff (RESET)
      CE_RESET |-> $past(slow_tick) && $past(ce_pending_reg) && SLOW_TICK_FLAG;
   endproperty
   a_ce_fire: assert property (p_ce_fire) else $error("chip-enable reset off the slow pulse");

   property p_collision;
      @(posedge CLK) disable iff (RESET)
      slow_tick && ce_pending_reg && slow_read && ce_sync_reg |=> !CE_RESET && ce_pending_reg;
   endproperty
   a_collision: assert property (p_collision) else $error("read did not defer reset");

   property p_sticky;
      @(posedge CLK) disable iff (RESET)
      SLOW_TICK_FLAG && !slow_read |=> SLOW_TICK_FLAG;
   endproperty
   a_sticky: assert property (p_sticky) else $error("slow flag dropped without read");

   property p_fast_sticky;
      @(posedge CLK) disable iff (RESET)
      FAST_TICK_FLAG && !fast_read |=> FAST_TICK_FLAG;
   endproperty
   a_fast_sticky: assert property (p_fast_sticky) else $error("fast flag dropped without read");

   property p_fast_arm;
      @(posedge CLK) disable iff (RESET)
      $rose(FAST_TICK_FLAG) |-> $past(fast_armed_reg);
   endproperty
   a_fast_arm: assert property (p_fast_arm) else $error("fast flag set before first read");

   property p_fast_read_data;
      @(posedge CLK) disable iff (RESET)
      fast_read |=> DM_RDATA == {3'h0, $past(FAST_TICK_FLAG)};
   endproperty
   a_fast_read_data: assert property (p_fast_read_data) else $error("fast judge read data wrong");

   property p_slow_read_clear;
      @(posedge CLK) disable iff (RESET)
      slow_read && !slow_tick |=> !SLOW_TICK_FLAG;
   endproperty
   a_slow_read_clear: assert property (p_slow_read_clear) else $error("slow flag not cleared by read");

   property p_ce_drop;
      @(posedge CLK) disable iff (RESET)
      !ce_sync_reg |=> !ce_pending_reg;
   endproperty
   a_ce_drop: assert property (p_ce_drop) else $error("pending reset kept with enable low");
endmodule // ptf_tick_flags

/* File: tb/periodic_tick_flags_ce_reset_tb_top.sv */
`timescale 1ns/10ps
module periodic_tick_flags_ce_reset_tb_top;
   // ==========================================================
   // Signals
   localparam int FC   = 20;
   localparam int SLOW = FC * ptf_pkg::SLOW_PER_FAST;
   logic       clk;
   logic       reset;
   logic       ce;
   logic       clk_stop;
   logic [6:0] dm_addr;
   logic       dm_rd;
   logic [3:0] dm_rdata;
   logic       slow_flag;
   logic       fast_flag;
   logic       ce_reset;
   int         miscompares;
   int         samples_checked;
   int         cycles;
   int         n;
   logic [3:0] d;

   ptf_tick_flags #(.FAST_CYCLES(FC)) uut (
      .CLK(clk), .RESET(reset), .CE(ce), .CLK_STOP(clk_stop), .DM_ADDR(dm_addr), .DM_RD(dm_rd),
      .DM_RDATA(dm_rdata), .SLOW_TICK_FLAG(slow_flag), .FAST_TICK_FLAG(fast_flag), .CE_RESET(ce_reset));

   // ==========================================================
   // Clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         close_out();
      end
   end

   // ==========================================================
   // Tasks
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask

   // Read-and-clear access; data is taken one cycle after the strobe edge
   task automatic rd(input logic [6:0] a, output logic [3:0] v);
      @(posedge clk);
      dm_addr <= a;
      dm_rd   <= 1'b1;
      @(posedge clk);
      dm_rd   <= 1'b0;
      #1 v = dm_rdata;
   endtask

   // Edges until slow flag (0), fast flag (1) or chip-enable reset (2) is seen high
   task automatic wait_set(input int sel, input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (((sel == 0) ? slow_flag : (sel == 1) ? fast_flag : ce_reset) !== 1'b1 && k < lim);
   endtask

   // ==========================================================
   // Tests
   initial begin
      clk      = 1'b0;
      reset    = 1'b1;
      ce       = 1'b0;
      clk_stop = 1'b0;
      dm_addr  = 7'h00;
      dm_rd    = 1'b0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      // Flags stay clear until read once, even over a full slow period
      repeat (SLOW + 10) @(posedge clk);
      #1 chk(0, {slow_flag, fast_flag});
      rd(ptf_pkg::SLOW_TICK_JUDGE_ADDR, d);
      chk(0, d);
      rd(ptf_pkg::FAST_TICK_JUDGE_ADDR, d);
      chk(0, d);
      rd(7'h70, d);
      chk(0, d);
      $display("test power-on done");
      wait_set(1, FC + 5, n);
      rd(ptf_pkg::FAST_TICK_JUDGE_ADDR, d);
      chk(1, d);
      chk(0, fast_flag);
      wait_set(1, FC, n);
      chk(FC - 2, n);
      repeat (3 * FC + 5) @(posedge clk);
      #1 chk(1, fast_flag);
      rd(ptf_pkg::FAST_TICK_JUDGE_ADDR, d);
      chk(1, d);
      rd(ptf_pkg::FAST_TICK_JUDGE_ADDR, d);
      chk(0, d);
      $display("test fast flag done");
      // Chip enable is still low here, so the timebase runs without it
      wait_set(0, SLOW + 5, n);
      rd(ptf_pkg::SLOW_TICK_JUDGE_ADDR, d);
      chk(1, d);
      wait_set(0, SLOW, n);
      chk(SLOW - 2, n);
      $display("test slow flag done");
      wait_set(1, FC + 2, n);
      rd(ptf_pkg::FAST_TICK_JUDGE_ADDR, d);
      @(posedge clk);
      clk_stop <= 1'b1;
      repeat (3 * FC) @(posedge clk);
      #1 chk(0, fast_flag);
      @(posedge clk);
      clk_stop <= 1'b0;
      wait_set(1, FC + 2, n);
      chk(1, fast_flag);
      $display("test clock stop done");
      // The slow flag set before the stop is still held; clear it so the wait meets a fresh pulse
      rd(ptf_pkg::SLOW_TICK_JUDGE_ADDR, d);
      chk(1, d);
      // Align to a slow pulse so the chip-enable reset lands at a known edge
      wait_set(0, SLOW + 5, n);
      rd(ptf_pkg::SLOW_TICK_JUDGE_ADDR, d);
      @(posedge clk);
      ce <= 1'b1;
      wait_set(2, SLOW + 5, n);
      chk(SLOW - 3, n);
      chk(1, slow_flag);
      @(posedge clk);
      #1 chk(0, ce_reset);
      $display("test chip-enable reset done");
      @(posedge clk);
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      repeat (SLOW - 8) @(posedge clk);
      // Read lands on the pulse edge that would fire the pending reset
      rd(ptf_pkg::SLOW_TICK_JUDGE_ADDR, d);
      chk(1, d);
      wait_set(2, 20, n);
      chk(0, ce_reset);
      wait_set(2, SLOW, n);
      chk(SLOW - 20, n);
      // Restarted software reads the flag at once and sees the enable reset
      rd(ptf_pkg::SLOW_TICK_JUDGE_ADDR, d);
      chk(1, d);
      $display("test read collision done");
      close_out();
   end
endmodule // periodic_tick_flags_ce_reset_tb_top
